/* File: rtl/cca_pkg.sv */
// Shared constants and types of the counter array capture/compare logic
package cca_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NUM_MOD = 3;   // Number of capture/compare modules
  localparam int BYTE_W  = 8;   // Width of one compare byte
  localparam int CNT_W   = 16;  // Width of the shared counter
  localparam int MODE_W  = 8;   // Width of a module mode register

  // ==========================================================================
  // Mode register field positions
  // ==========================================================================
  localparam int BIT_WIDE_PWM  = 7;  // Wide PWM select
  localparam int BIT_CMP_EN    = 6;  // Compare enable
  localparam int BIT_CAP_RISE  = 5;  // Capture on rising edge
  localparam int BIT_CAP_FALL  = 4;  // Capture on falling edge
  localparam int BIT_MATCH_EN  = 3;  // Match flag enable
  localparam int BIT_TOGGLE_EN = 2;  // Toggle enable
  localparam int BIT_PULSE_MOD = 1;  // Pulse modulation enable
  localparam int BIT_FLAG_IRQ  = 0;  // Flag interrupt enable

  // ==========================================================================
  // Reset values, wrap limits and counter step
  // ==========================================================================
  localparam logic [MODE_W-1:0] MODE_RST = 8'h00;   // Mode register reset
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;   // Compare byte reset
  localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000; // Counter reset
  localparam logic [BYTE_W-1:0] BYTE_MAX = 8'hFF;   // Low byte before wrap
  localparam logic [CNT_W-1:0]  CNT_MAX  = 16'hFFFF; // Counter before wrap
  localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001; // Counter step

  // ==========================================================================
  // Operating modes
  // ==========================================================================
  typedef enum logic [2:0] {
    CCA_IDLE,
    CCA_CAPTURE,
    CCA_SW_TIMER,
    CCA_HS_OUT,
    CCA_FREQ_OUT,
    CCA_PWM8,
    CCA_WIDE_PWM_SELECT
  } cca_mode_t;

  // Decode a mode register into its operating mode
  function automatic cca_mode_t cca_decode(input logic [MODE_W-1:0] m);
    logic cap;
    cap = m[BIT_CAP_RISE] | m[BIT_CAP_FALL];
    if (cap)
    begin
      if (!m[BIT_MATCH_EN] && !m[BIT_TOGGLE_EN] && !m[BIT_PULSE_MOD])
        return CCA_CAPTURE;
      return CCA_IDLE;
    end
    if (m[BIT_PULSE_MOD] && m[BIT_TOGGLE_EN])
      return m[BIT_CMP_EN] ? CCA_FREQ_OUT : CCA_IDLE;
    if (m[BIT_PULSE_MOD])
      return m[BIT_WIDE_PWM] ? CCA_WIDE_PWM_SELECT : CCA_PWM8;
    if (m[BIT_CMP_EN] && m[BIT_MATCH_EN])
      return m[BIT_TOGGLE_EN] ? CCA_HS_OUT : CCA_SW_TIMER;
    return CCA_IDLE;
  endfunction

endpackage

/* File: rtl/cca_edge.sv */
// Pin edge detector that selects the capture edges of one module
module cca_edge
  import cca_pkg::*;
(
  input  wire logic core_clk_i,   // System clock
  input  wire logic resetn_i,     // Asynchronous reset, active low
  input  wire logic pin_i,        // Module pin level
  input  wire logic rise_en_i,    // Capture on rising edge
  input  wire logic fall_en_i,    // Capture on falling edge
  input  wire logic armed_i,      // Module is in capture mode
  output logic      capture_o     // One-cycle capture request
);

  logic prev;   // Pin level one cycle ago
  wire  rise;   // Rising edge seen
  wire  fall;   // Falling edge seen

  // ==========================================================================
  // Edge detection
  // ==========================================================================
  // Remember the previous pin level
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prev <= 1'b0;
    else
      prev <= pin_i;
  end

  assign rise = pin_i & ~prev;
  assign fall = ~pin_i & prev;

  // Both enables give capture on any transition
  assign capture_o = armed_i & ((rise_en_i & rise) | (fall_en_i & fall));

endmodule

/* File: rtl/cca_top.sv */
// Counter array with capture/compare modules sharing one 16-bit counter
// Behaviour
// - Each module picks one of six modes
// - Capture on rising, falling or any edge
// - High-speed output: compare, match, toggle enabled
// - High-speed output toggles pin on 16-bit match
// - Wide select picks 8-bit or 16-bit PWM
// - Flag interrupts need the module enable bit
// - Interrupts need global and array enables
// - Low write clears, high write sets compare
// - 8-bit PWM sets pin on low match
// - 8-bit PWM clears pin on low overflow unless high is zero
// - In 8-bit PWM, low byte reloads from high on wrap
// - Duty equals 256 minus high, over 256
// - Compare disabled in 8-bit PWM gives low
module cca_top
  import cca_pkg::*;
(
  input  wire logic                  core_clk_i,          // System clock, 10 MHz
  input  wire logic                  resetn_i,            // Asynchronous reset, active low
  input  wire logic                  counter_run_i,       // Shared counter counts when high
  input  wire logic [NUM_MOD-1:0]    mode_wr_i,           // Mode register write strobes
  input  wire logic [NUM_MOD-1:0]    cmp_low_wr_i,        // Compare low byte write strobes
  input  wire logic [NUM_MOD-1:0]    cmp_high_wr_i,       // Compare high byte write strobes
  input  wire logic [BYTE_W-1:0]     wdata_i,             // Write data for all strobes
  input  wire logic [NUM_MOD-1:0]    flag_clr_i,          // Event flag clear strobes
  input  wire logic                  global_irq_enable_i, // Global interrupt enable
  input  wire logic                  array_irq_enable_i,  // Counter array interrupt enable
  input  wire logic [NUM_MOD-1:0]    module_io_pin_i,     // Pin levels seen at the pins
  output logic [NUM_MOD-1:0]         module_io_pin_o,     // Pin drive levels
  output logic [NUM_MOD-1:0]         module_io_pin_oe_n_o, // Pin drive enables, low drives
  output logic [NUM_MOD*MODE_W-1:0]  module_mode_reg_o,   // Mode registers, module 0 lowest
  output logic [NUM_MOD*BYTE_W-1:0]  compare_low_byte_o,  // Compare low bytes
  output logic [NUM_MOD*BYTE_W-1:0]  compare_high_byte_o, // Compare high bytes
  output logic [NUM_MOD-1:0]         module_event_flag_o, // Event flags
  output logic [CNT_W-1:0]           counter_o,           // Shared counter value
  output logic                       irq_o                // Interrupt request
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [CNT_W-1:0]  counter;                  // Shared free-running counter
  logic [MODE_W-1:0] mode_reg  [NUM_MOD];      // Module mode registers
  logic [BYTE_W-1:0] cmp_low   [NUM_MOD];      // Compare low bytes
  logic [BYTE_W-1:0] cmp_high  [NUM_MOD];      // Compare high bytes
  logic [NUM_MOD-1:0] event_flag;              // Module event flags
  logic [NUM_MOD-1:0] pin_level;               // Pin drive levels
  logic [NUM_MOD-1:0] pin_oe_n;                // Pin drive enables
  logic              irq;                      // Registered interrupt request

  // ==========================================================================
  // Shared counter
  // ==========================================================================
  wire               tick;                     // Counter advances this cycle
  wire               low_wrap;                 // Low byte wraps 0xFF to 0x00
  wire               full_wrap;                // Counter wraps to zero
  wire [NUM_MOD-1:0] flag_irq;                 // Enabled pending flags
  wire [CNT_W-1:0]   next_count;               // Counter value after this tick

  assign tick       = counter_run_i;
  assign next_count = counter + CNT_ONE;
  assign low_wrap  = tick & (counter[BYTE_W-1:0] == BYTE_MAX);
  assign full_wrap = tick & (counter == CNT_MAX);

  // Count the timebase while running
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      counter <= CNT_RST;
    else if (tick)
      counter <= next_count;
  end

  // ==========================================================================
  // Capture/compare modules
  // ==========================================================================
  generate
    for (genvar i = 0; i < NUM_MOD; i++)
    begin : g_mod
      cca_mode_t         mode;                 // Decoded operating mode
      wire               cmp_en;               // Compare enable bit
      wire               match16;              // Counter equals 16-bit compare
      wire               match8;               // Low byte equals compare low
      wire               capture;              // Selected capture edge
      wire               hit;                  // Event that sets the flag
      wire               pin_set;              // Drive pin high
      wire               pin_clr;              // Drive pin low
      wire               pin_tog;              // Invert pin
      wire               reload;               // Low byte takes high byte
      wire               pwm8_enter;           // Low byte steps onto the duty byte
      wire [MODE_W-1:0]  next_mode;            // Mode with compare enable effects
      wire [BYTE_W-1:0]  next_low;             // Next compare low byte
      wire [BYTE_W-1:0]  next_high;            // Next compare high byte
      wire               next_pin;             // Next pin level

      assign mode    = cca_decode(mode_reg[i]);
      assign cmp_en  = mode_reg[i][BIT_CMP_EN];
      assign match16 = cmp_en & tick & (counter == {cmp_high[i], cmp_low[i]});
      assign match8  = cmp_en & tick & (counter[BYTE_W-1:0] == cmp_low[i]);

      // Edge selection for capture mode
      cca_edge u_edge (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .pin_i      (module_io_pin_i[i]),
        .rise_en_i  (mode_reg[i][BIT_CAP_RISE]),
        .fall_en_i  (mode_reg[i][BIT_CAP_FALL]),
        .armed_i    (mode == CCA_CAPTURE),
        .capture_o  (capture)
      );

      // Flag sources per mode
      assign hit = capture
                 | ((mode == CCA_SW_TIMER) & match16)
                 | ((mode == CCA_HS_OUT) & match16)
                 | ((mode == CCA_PWM8) & mode_reg[i][BIT_MATCH_EN] & match8)
                 | ((mode == CCA_WIDE_PWM_SELECT) & mode_reg[i][BIT_MATCH_EN] & match16);

      // PWM8 sets as the low byte reaches its duty byte, so the pin is high
      // for 256 minus duty counts; a zero duty byte holds it through the wrap
      assign pwm8_enter = cmp_en & tick &
                          (next_count[BYTE_W-1:0] == (low_wrap ? cmp_high[i] : cmp_low[i]));

      // Pin actions; PWM8 clears on low wrap unless the new duty byte sets it
      assign pin_tog = ((mode == CCA_HS_OUT) & match16)
                     | ((mode == CCA_FREQ_OUT) & match8);
      assign pin_set = ((mode == CCA_PWM8) & pwm8_enter)
                     | ((mode == CCA_WIDE_PWM_SELECT) & match16);
      assign pin_clr = ((mode == CCA_PWM8) & (~cmp_en | (low_wrap & ~pwm8_enter)))
                     | ((mode == CCA_WIDE_PWM_SELECT) & (full_wrap | ~cmp_en));
      assign next_pin = pin_clr ? 1'b0 :
                        pin_set ? 1'b1 :
                        pin_tog ? ~pin_level[i] : pin_level[i];

      // Automatic reload of the duty byte in 8-bit PWM
      assign reload = (mode == CCA_PWM8) & low_wrap;

      // Software writes win over hardware updates of the compare bytes
      assign next_low  = cmp_low_wr_i[i]  ? wdata_i :
                         capture          ? counter[BYTE_W-1:0] :
                         reload           ? cmp_high[i] :
                         ((mode == CCA_FREQ_OUT) & match8) ? cmp_low[i] + cmp_high[i] :
                         cmp_low[i];
      assign next_high = cmp_high_wr_i[i] ? wdata_i :
                         capture          ? counter[CNT_W-1:BYTE_W] :
                         cmp_high[i];

      // Compare byte writes steer compare enable; high write wins when both
      assign next_mode = cmp_high_wr_i[i] ? (mode_reg[i] |  (MODE_W'(1) << BIT_CMP_EN)) :
                         cmp_low_wr_i[i]  ? (mode_reg[i] & ~(MODE_W'(1) << BIT_CMP_EN)) :
                         mode_wr_i[i]     ? wdata_i : mode_reg[i];

      // Mode and compare registers
      always_ff @(posedge core_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          mode_reg[i] <= MODE_RST;
          cmp_low[i]  <= BYTE_RST;
          cmp_high[i] <= BYTE_RST;
        end
        else
        begin
          mode_reg[i] <= next_mode;
          cmp_low[i]  <= next_low;
          cmp_high[i] <= next_high;
        end
      end

      // Event flag; a set in the clear cycle wins
      always_ff @(posedge core_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
          event_flag[i] <= 1'b0;
        else if (hit)
          event_flag[i] <= 1'b1;
        else if (flag_clr_i[i])
          event_flag[i] <= 1'b0;
      end

      // Pin drive; capture and idle modes leave the pin to the outside
      always_ff @(posedge core_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          pin_level[i] <= 1'b0;
          pin_oe_n[i]  <= 1'b1;
        end
        else
        begin
          pin_level[i] <= next_pin;
          pin_oe_n[i]  <= (mode == CCA_CAPTURE) | (mode == CCA_IDLE);
        end
      end

      assign flag_irq[i] = event_flag[i] & mode_reg[i][BIT_FLAG_IRQ];

      assign module_mode_reg_o[i*MODE_W +: MODE_W]   = mode_reg[i];
      assign compare_low_byte_o[i*BYTE_W +: BYTE_W]  = cmp_low[i];
      assign compare_high_byte_o[i*BYTE_W +: BYTE_W] = cmp_high[i];
    end
  endgenerate

  // ==========================================================================
  // Interrupt request
  // ==========================================================================
  // Recognised only under both the global and the array enables
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      irq <= 1'b0;
    else
      irq <= global_irq_enable_i & array_irq_enable_i & (|flag_irq);
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign module_io_pin_o      = pin_level;
  assign module_io_pin_oe_n_o = pin_oe_n;
  assign module_event_flag_o  = event_flag;
  assign counter_o            = counter;
  assign irq_o                = irq;

endmodule

/* File: tb/cca_pin_src.sv */
// Signal source and pull-up load standing at the module pins
module cca_pin_src
  import cca_pkg::*;
(
  input  wire logic [NUM_MOD-1:0] pin_o_i,   // Device drive levels
  input  wire logic [NUM_MOD-1:0] oe_n_i,    // Device drive enables, low drives
  input  wire logic [NUM_MOD-1:0] src_en_i,  // Source drives the pin
  input  wire logic [NUM_MOD-1:0] src_val_i, // Source level
  output logic      [NUM_MOD-1:0] level_o    // Resolved wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Wire resolution
  // ==========================================================================
  // Device wins where it drives, else the source where enabled; a wire neither drives rises to the pull-up
  always_comb
    for (int i = 0; i < NUM_MOD; i++)
      level_o[i] = !oe_n_i[i] ? pin_o_i[i] : (src_en_i[i] ? src_val_i[i] : 1'b1);
endmodule

/* File: tb/cca_top_props.sv */
// Concurrent checks of module 0 and of the interrupt request of the capture/compare block
module cca_top_props
  import cca_pkg::*;
(
  input wire logic                      core_clk_i,          // Clock
  input wire logic                      resetn_i,            // Reset, active low
  input wire logic                      counter_run_i,       // Counter enable
  input wire logic [NUM_MOD-1:0]        mode_wr_i,           // Mode writes
  input wire logic [NUM_MOD-1:0]        cmp_low_wr_i,        // Low writes
  input wire logic [NUM_MOD-1:0]        cmp_high_wr_i,       // High writes
  input wire logic [BYTE_W-1:0]         wdata_i,             // Write data
  input wire logic                      global_irq_enable_i, // Global enable
  input wire logic                      array_irq_enable_i,  // Array enable
  input wire logic [NUM_MOD-1:0]        module_io_pin_i,     // Pin levels
  input wire logic [NUM_MOD-1:0]        module_io_pin_o,     // Pin drive
  input wire logic [NUM_MOD*MODE_W-1:0] module_mode_reg_o,   // Modes
  input wire logic [NUM_MOD*BYTE_W-1:0] compare_low_byte_o,  // Low bytes
  input wire logic [NUM_MOD*BYTE_W-1:0] compare_high_byte_o, // High bytes
  input wire logic [NUM_MOD-1:0]        module_event_flag_o, // Flags
  input wire logic [CNT_W-1:0]          counter_o,           // Counter
  input wire logic                      irq_o                // Interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Helper decode
  // ==========================================================================
  logic [7:0]  m_q;                             // Mode one cycle ago
  wire  [7:0]  m   = module_mode_reg_o[7:0];    // Mode register
  wire  [7:0]  lo  = compare_low_byte_o[7:0];   // Compare low
  wire  [7:0]  hi  = compare_high_byte_o[7:0];  // Compare high
  wire  [15:0] c   = counter_o;                 // Counter
  wire         pin = module_io_pin_o[0];        // Pin drive
  wire         q   = !mode_wr_i[0] && !cmp_low_wr_i[0] && !cmp_high_wr_i[0] && m == m_q; // Settled
  wire         t   = counter_run_i && q;        // Settled tick
  wire         m16 = c == {hi, lo};             // Full match
  wire         cap = (m & 8'h0E) == 8'h00 && m[5:4] != 2'b00; // Capture mode
  wire         req = |(module_event_flag_o & {module_mode_reg_o[16], module_mode_reg_o[8], m[0]});
  // Previous mode for the settled test
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
      m_q <= 8'h00;
    else
      m_q <= m;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // PWM8 low byte wrap, and compare enable held off
  sequence s_wrap; t && (m & 8'hF6) == 8'h42 && c[7:0] == 8'hFF && lo != 8'hFF; endsequence
  sequence s_off; ((m & 8'hF6) == 8'h02) [*2]; endsequence
  // ==========================================================================
  // Assertions
  // ==========================================================================
  low_wr_clr_a: assert property (cmp_low_wr_i[0] && !cmp_high_wr_i[0] |=> !m[6] && lo == $past(wdata_i))
    else $error("low write did not clear compare enable");
  high_wr_set_a: assert property (cmp_high_wr_i[0] |=> m[6] && hi == $past(wdata_i))
    else $error("high write did not set compare enable");
  swt_flag_a: assert property (t && (m & 8'h7E) == 8'h48 && m16 |=> module_event_flag_o[0])
    else $error("timer match did not set flag");
  hso_toggle_a: assert property (t && (m & 8'h7E) == 8'h4C && m16 |=> pin != $past(pin))
    else $error("output match did not toggle pin");
  freq_step_a: assert property (t && (m & 8'h76) == 8'h46 && c[7:0] == lo |=> pin != $past(pin) && lo == $past(lo) + $past(hi))
    else $error("frequency step wrong");
  pwm8_set_a: assert property (t && (m & 8'hF6) == 8'h42 && c[7:0] == lo && lo != 8'hFF |=> pin)
    else $error("pwm8 match did not set pin");
  pwm8_wrap_a: assert property (s_wrap |=> pin == ($past(hi) == 8'h00) && lo == $past(hi))
    else $error("pwm8 wrap wrong");
  pwm8_off_a: assert property (s_off |-> !pin)
    else $error("pwm8 disabled pin high");
  wide_pwm_select_set_a: assert property (t && (m & 8'hF6) == 8'hC2 && m16 && c != 16'hFFFF |=> pin)
    else $error("wide_pwm_select match did not set pin");
  capture_a: assert property (cap && q && (($rose(module_io_pin_i[0]) && m[5]) || ($fell(module_io_pin_i[0]) && m[4]))
    |=> {hi, lo} == $past(c) && module_event_flag_o[0])
    else $error("capture missed");
  cap_hold_a: assert property (cap && q && !(($rose(module_io_pin_i[0]) && m[5]) || ($fell(module_io_pin_i[0]) && m[4]))
    |=> $stable(lo) && $stable(hi))
    else $error("capture on unselected edge");
  irq_gate_a: assert property (irq_o == $past(global_irq_enable_i && array_irq_enable_i && req))
    else $error("interrupt gating wrong");
endmodule
bind cca_top cca_top_props i_props (.*);

/* File: tb/cca_top_tb.sv */
// Self-checking bench of the capture/compare block
module cca_top_tb
  import cca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;   // System clock
  logic        rst_n = 1'b0; // Reset, active low
  logic        run = 1'b0;   // Counter enable
  logic [2:0]  mw = 3'h0;    // Mode write strobes
  logic [2:0]  lw = 3'h0;    // Low write strobes
  logic [2:0]  hw = 3'h0;    // High write strobes
  logic [2:0]  fc = 3'h0;    // Flag clears
  logic [2:0]  sval = 3'h0;  // Source levels
  logic [7:0]  wd = 8'h00;   // Write data
  logic        ge = 1'b0;    // Global enable
  logic        ae = 1'b0;    // Array enable
  logic [15:0] cm = 16'h0000; // Counter model
  wire  [2:0]  pin_i, pin_o, oe_n, flag; // Pin and flag lines
  wire  [23:0] mode, low, high; // Register outputs
  wire  [15:0] cnt;          // Counter output
  wire         irq;          // Interrupt request
  int          failures = 0; // Mismatches
  int          n_checks = 0; // Comparisons
  cca_top i_dut (.core_clk_i(clk), .resetn_i(rst_n), .counter_run_i(run), .mode_wr_i(mw), .cmp_low_wr_i(lw),
    .cmp_high_wr_i(hw), .wdata_i(wd), .flag_clr_i(fc), .global_irq_enable_i(ge), .array_irq_enable_i(ae),
    .module_io_pin_i(pin_i), .module_io_pin_o(pin_o), .module_io_pin_oe_n_o(oe_n), .module_mode_reg_o(mode),
    .compare_low_byte_o(low), .compare_high_byte_o(high), .module_event_flag_o(flag), .counter_o(cnt), .irq_o(irq));
  cca_pin_src i_pins (.pin_o_i(pin_o), .oe_n_i(oe_n), .src_en_i(3'h7), .src_val_i(sval), .level_o(pin_i));
  // ==========================================================================
  // Clock, counter model, tasks
  // ==========================================================================
  initial
    forever #50 clk = ~clk;
  // Expected counter, pre-increment value at each edge
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      cm <= 16'h0000;
    else if (run)
      cm <= cm + 16'h0001;
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write strobe stays high until the next wr or cyc clears it
  task automatic wr(input int k, input int i, input logic [7:0] d);
    wd = d;
    mw = (k == 0) ? 3'h1 << i : 3'h0;
    lw = (k == 1) ? 3'h1 << i : 3'h0;
    hw = (k == 2) ? 3'h1 << i : 3'h0;
    @(negedge clk);
  endtask
  task automatic ld(input int i, input logic [15:0] v);
    wr(1, i, v[7:0]);
    wr(2, i, v[15:8]);
  endtask
  task automatic cyc(input int n);
    mw = 3'h0;
    lw = 3'h0;
    hw = 3'h0;
    repeat (n) @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial
  begin
    #2000000;
    failures++;
    print_verdict();
  end
  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial
  begin
    logic [15:0] v;
    logic [15:0] c0;
    logic [7:0]  h;
    logic        p;
    int          hc;
    void'($urandom(82));
    cyc(6);
    rst_n = 1'b1;
    cyc(1);
    chk("reset_mode", mode, 24'h000000);
    chk("reset_pins", {17'h00000, oe_n, pin_o, irq}, 24'h000070);
    chk("reset_flags", {flag, 5'h00, cnt}, 24'h000000);
    // Compare writes per module, then distinct modes
    for (int i = 0; i < NUM_MOD; i++)
    begin
      v = 16'($urandom);
      wr(0, i, 8'h40 | 8'(2 * i));
      wr(1, i, v[7:0]);
      cyc(1);
      chk("cmp_en_low", 24'(mode[8 * i + 6]), 24'h000000);
      wr(2, i, v[15:8]);
      cyc(1);
      chk("cmp_en_high", 24'(mode[8 * i + 6]), 24'h000001);
      chk("cmp_value", 24'({high[8 * i +: 8], low[8 * i +: 8]}), 24'(v));
    end
    chk("modes", mode, 24'h444240);
    run = 1'b1;
    // Capture on fall, rise and both edges
    for (int j = 0; j < 3; j++)
    begin
      h = 8'h01 | 8'((j + 1) << 4);
      wr(0, 0, h);
      repeat (2)
      begin
        fc = 3'h1;
        cyc(3);
        fc = 3'h0;
        v = {high[7:0], low[7:0]};
        sval[0] = ~sval[0];
        c0 = cm;
        cyc(1);
        p = sval[0] ? h[5] : h[4];
        chk("capture", 24'({high[7:0], low[7:0]}), 24'(p ? c0 : v));
        chk("cap_flag", 24'(flag[0]), 24'(p));
      end
    end
    for (int k = 0; k < 4; k++)
    begin
      ge = k[0];
      ae = k[1];
      cyc(2);
      chk("irq_gate", 24'(irq), 24'(k == 3));
    end
    wr(0, 0, 8'h30);
    cyc(2);
    chk("irq_mask", 24'(irq), 24'h000000);
    // Software timer then high-speed output
    for (int j = 0; j < 2; j++)
    begin
      wr(0, 0, j ? 8'h4D : 8'h49);
      ld(0, cm + 16'h0028);
      fc = 3'h1;
      cyc(1);
      fc = 3'h0;
      p = pin_o[0];
      cyc(50);
      chk("match_flag", 24'({flag[0], irq}), 24'h000003);
      chk("match_pin", 24'(pin_o[0]), 24'(p ^ j[0]));
    end
    // Frequency output step
    wr(0, 0, 8'h46);
    h = 8'h40 | 8'($urandom_range(63, 0));
    v = {h, cm[7:0] + 8'h18};
    ld(0, v);
    cyc(30);
    chk("freq_low", 24'(low[7:0]), 24'(8'(v[7:0] + h)));
    chk("freq_oe", 24'(oe_n[0]), 24'h000000);
    // PWM8 duty over a full low byte period
    for (int j = 0; j < 5; j++)
    begin
      h = (j == 0) ? 8'h01 : (j == 1) ? 8'hFF : 8'($urandom_range(254, 2));
      if (j < 4)
      begin
        wr(0, 0, 8'h42);
        ld(0, {h, h});
      end
      else
        wr(1, 0, h);
      cyc(300);
      hc = 0;
      repeat (256)
      begin
        @(negedge clk);
        hc += pin_o[0];
      end
      chk("pwm8_duty", 24'(hc), (j < 4) ? 24'(256 - h) : 24'h0);
    end
    // WIDE_PWM_SELECT set on full match
    wr(0, 0, 8'hC2);
    ld(0, cm + 16'h0028);
    cyc(1);
    chk("wide_pwm_select_before", 24'(pin_o[0]), 24'h000000);
    cyc(50);
    chk("wide_pwm_select_after", 24'(pin_o[0]), 24'h000001);
    chk("counter", 24'(cnt), 24'(cm));
    print_verdict();
  end
endmodule
